// >>> verilog/tws_pkg.sv
// shared constants, types and register map of the two-wire slave receiver
// assumes a 100 MHz pclk and a 32-bit apb register port on the device end
package tws_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_SAR  = 8'h00;
  localparam logic [7:0] OFF_CTL  = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;

  // two_wire_control bit positions
  localparam int CTL_FLAG = 7;
  localparam int CTL_EA   = 6;
  localparam int CTL_STA  = 5;
  localparam int CTL_STO  = 4;
  localparam int CTL_WC   = 3;
  localparam int CTL_EN   = 2;
  localparam int CTL_IE   = 0;

  // values after reset
  localparam logic [7:0] SAR_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hFF;

  // bus_status_code values, prescaler bits zero
  localparam logic [7:0] STAT_IDLE   = 8'hF8;
  localparam logic [7:0] STAT_OWN    = 8'h60;
  localparam logic [7:0] STAT_OWN_AL = 8'h68;
  localparam logic [7:0] STAT_GC     = 8'h70;
  localparam logic [7:0] STAT_GC_AL  = 8'h78;
  localparam logic [7:0] STAT_DAT_A  = 8'h80;
  localparam logic [7:0] STAT_DAT_N  = 8'h88;
  localparam logic [7:0] STAT_GDAT_A = 8'h90;
  localparam logic [7:0] STAT_GDAT_N = 8'h98;
  localparam logic [7:0] STAT_STOP   = 8'hA0;
  localparam logic [2:0] PRESC_MASK  = 3'h0;

  localparam logic [6:0] GC_ADDR   = 7'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // master timing: one bit is four quarters
  localparam int CLK_MHZ  = 100;
  localparam int QTR_NS   = 250;
  localparam int QTR_CYC  = (QTR_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_BYTE  = 2'h1,
    OP_STOP  = 2'h2
  } tws_op_t;

  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_ADDR = 5'h02,
    D_AACK = 5'h04,
    D_DATA = 5'h08,
    D_DACK = 5'h10
  } tws_dst_t;

  typedef enum logic [3:0] {
    M_WAIT = 4'h1,
    M_STA  = 4'h2,
    M_BIT  = 4'h4,
    M_STO  = 4'h8
  } tws_mst_t;

endpackage

// >>> verilog/tws_bus_if.sv
// two-wire bus joining the master transmitter end and the slave receiver end
// both lines are open drain with pull-up: an enabled driver pulls low
`timescale 1ns/1ps
`default_nettype none
interface tws_bus_if;
  logic scl;
  logic sda;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_scl_o;
  logic s_scl_oe;
  logic s_sda_o;
  logic s_sda_oe;

  assign scl = (~m_scl_oe | m_scl_o) & (~s_scl_oe | s_scl_o);
  assign sda = (~m_sda_oe | m_sda_o) & (~s_sda_oe | s_sda_o);

  modport mst (input scl, input sda, output m_scl_o, output m_scl_oe,
               output m_sda_o, output m_sda_oe);
  modport dev (input scl, input sda, output s_scl_o, output s_scl_oe,
               output s_sda_o, output s_sda_oe);
endinterface
`default_nettype wire

// >>> verilog/tws_mst.sv
// master transmitter end: start, byte and stop commands onto the two-wire bus
// assumes the slave may stretch scl; the clock is made here by a quarter divider
`timescale 1ns/1ps
`default_nettype none
module tws_mst
  import tws_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       cmd_valid,
  input  wire tws_op_t    cmd_op,
  input  wire logic [7:0] cmd_byte,
  output logic            cmd_ready,
  output logic            nack_seen,
  tws_bus_if.mst          bus
);

  typedef struct packed {
    tws_mst_t    st;
    logic [1:0]  step;
    logic [3:0]  bitn;
    logic [15:0] tmr;
    logic [7:0]  sh;
    logic [2:0]  scl_q;
    logic [2:0]  sda_q;
    logic        scl_f;
    logic        sda_f;
    logic        scl_oe;
    logic        sda_oe;
    logic        nack;
  } tws_mreg_t;

  localparam tws_mreg_t M_RST = '{st: M_WAIT, scl_q: 3'h7, sda_q: 3'h7,
                                  scl_f: 1'b1, sda_f: 1'b1, default: '0};

  tws_mreg_t s_r;
  tws_mreg_t s_nxt;
  logic      adv;
  logic      enter;

  always_comb begin
    s_nxt = s_r;
    adv   = 1'b0;
    enter = 1'b0;
    s_nxt.scl_q = {s_r.scl_q[1:0], bus.scl};
    s_nxt.sda_q = {s_r.sda_q[1:0], bus.sda};
    if (s_r.scl_q[1] == s_r.scl_q[2]) begin
      s_nxt.scl_f = s_r.scl_q[2];
    end
    if (s_r.sda_q[1] == s_r.sda_q[2]) begin
      s_nxt.sda_f = s_r.sda_q[2];
    end
    if (s_r.tmr != 16'h0000) begin
      s_nxt.tmr = s_r.tmr - 16'h0001;
    end
    // a released scl ends its quarter only once the line is seen high
    adv = (s_r.st != M_WAIT) && (s_r.tmr == 16'h0000) && ((s_r.step != 2'h1) || s_r.scl_f);
    if (s_r.st == M_WAIT) begin
      if (cmd_valid) begin
        enter      = 1'b1;
        s_nxt.step = 2'h0;
        s_nxt.bitn = 4'h0;
        s_nxt.sh   = cmd_byte;
        unique case (cmd_op)
          OP_START: s_nxt.st = M_STA;
          OP_BYTE:  s_nxt.st = M_BIT;
          default:  s_nxt.st = M_STO;
        endcase
      end
    end else if (adv) begin
      enter = 1'b1;
      if (s_r.step == 2'h3) begin
        if ((s_r.st != M_BIT) || (s_r.bitn == BYTE_BITS)) begin
          s_nxt.st = M_WAIT;
        end else begin
          s_nxt.step = 2'h0;
          s_nxt.bitn = s_r.bitn + 4'h1;
          s_nxt.sh   = {s_r.sh[6:0], 1'b0};
        end
      end else begin
        s_nxt.step = s_r.step + 2'h1;
      end
    end
    if (enter && (s_nxt.st != M_WAIT)) begin
      s_nxt.tmr = 16'(QTR - 1);
      unique case (s_nxt.st)
        M_STA: begin
          unique case (s_nxt.step)
            2'h0: s_nxt.sda_oe = 1'b0;
            2'h1: s_nxt.scl_oe = 1'b0;
            2'h2: s_nxt.sda_oe = 1'b1;
            default: s_nxt.scl_oe = 1'b1;
          endcase
        end
        M_BIT: begin
          unique case (s_nxt.step)
            2'h0: s_nxt.sda_oe = (s_nxt.bitn == BYTE_BITS) ? 1'b0 : ~s_nxt.sh[7];
            2'h1: s_nxt.scl_oe = 1'b0;
            2'h2: begin
              if (s_nxt.bitn == BYTE_BITS) begin
                s_nxt.nack = s_r.sda_f;
              end
            end
            default: s_nxt.scl_oe = 1'b1;
          endcase
        end
        M_STO: begin
          unique case (s_nxt.step)
            2'h0: s_nxt.sda_oe = 1'b1;
            2'h1: s_nxt.scl_oe = 1'b0;
            2'h2: s_nxt.sda_oe = 1'b0;
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= M_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cmd_ready    = (s_r.st == M_WAIT);
  assign nack_seen    = s_r.nack;
  assign bus.m_scl_o  = 1'b0;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_scl_oe = s_r.scl_oe;
  assign bus.m_sda_oe = s_r.sda_oe;

endmodule
`default_nettype wire

// >>> verilog/tws_dev.sv
// slave receiver end: own address and general call match, byte reception,
// status codes and scl stretching, registers on an apb slave port
// assumes a master transmitter on the bus and software on the apb side
`timescale 1ns/1ps
`default_nettype none
module tws_dev
  import tws_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep_mode,
  input  wire logic        arb_lost,
  output logic             wake_req,
  tws_bus_if.dev           bus
);

  typedef struct packed {
    tws_dst_t   st;
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic       scl_f;
    logic       sda_f;
    logic [7:0] sar;
    logic [7:0] stat;
    logic [7:0] data;
    logic [7:0] sh;
    logic [7:0] rdata;
    logic [3:0] cnt;
    logic       flag;
    logic       ea;
    logic       sta;
    logic       sto;
    logic       en;
    logic       ie;
    logic       gc;
    logic       ackd;
    logic       sda_drv;
    logic       hold;
    logic       wake;
    logic       addrd;
  } tws_dreg_t;

  localparam tws_dreg_t D_RST = '{st: D_IDLE, scl_q: 3'h7, sda_q: 3'h7,
                                  scl_f: 1'b1, sda_f: 1'b1, sar: SAR_RST,
                                  stat: STAT_IDLE, data: DATA_RST, default: '0};

  tws_dreg_t s_r;
  tws_dreg_t s_nxt;
  logic      scl_rise;
  logic      scl_fall;
  logic      start_seen;
  logic      stop_seen;
  logic      own_hit;
  logic      gc_hit;
  logic      unmapped;
  logic      wr_acc;

  assign unmapped = (paddr != OFF_SAR) && (paddr != OFF_CTL) &&
                    (paddr != OFF_STAT) && (paddr != OFF_DATA);
  assign wr_acc   = psel && penable && pwrite && !unmapped;

  always_comb begin
    s_nxt = s_r;
    // the filtered line changes only when the second and third stages agree
    s_nxt.scl_q = {s_r.scl_q[1:0], bus.scl};
    s_nxt.sda_q = {s_r.sda_q[1:0], bus.sda};
    if (s_r.scl_q[1] == s_r.scl_q[2]) begin
      s_nxt.scl_f = s_r.scl_q[2];
    end
    if (s_r.sda_q[1] == s_r.sda_q[2]) begin
      s_nxt.sda_f = s_r.sda_q[2];
    end
    scl_rise   = ~s_r.scl_f & s_nxt.scl_f;
    scl_fall   = s_r.scl_f & ~s_nxt.scl_f;
    start_seen = s_r.scl_f & s_nxt.scl_f & s_r.sda_f & ~s_nxt.sda_f;
    stop_seen  = s_r.scl_f & s_nxt.scl_f & ~s_r.sda_f & s_nxt.sda_f;
    own_hit    = (s_r.sh[7:1] == s_r.sar[7:1]);
    gc_hit     = (s_r.sh[7:1] == GC_ADDR) & s_r.sar[0];

    // register reads are captured in the setup cycle
    if (psel && !penable) begin
      unique case (paddr)
        OFF_SAR:  s_nxt.rdata = s_r.sar;
        OFF_CTL:  s_nxt.rdata = {s_r.flag, s_r.ea, s_r.sta, s_r.sto, 1'b0, s_r.en, 1'b0, s_r.ie};
        OFF_STAT: s_nxt.rdata = {s_r.stat[7:3], PRESC_MASK};
        OFF_DATA: s_nxt.rdata = s_r.data;
        default:  s_nxt.rdata = 8'h00;
      endcase
    end
    if (wr_acc) begin
      unique case (paddr)
        OFF_SAR: s_nxt.sar = pwdata[7:0];
        OFF_CTL: begin
          s_nxt.ea  = pwdata[CTL_EA];
          s_nxt.sta = pwdata[CTL_STA];
          s_nxt.sto = pwdata[CTL_STO];
          s_nxt.en  = pwdata[CTL_EN];
          s_nxt.ie  = pwdata[CTL_IE];
          if (pwdata[CTL_FLAG]) begin
            s_nxt.flag = 1'b0;
            s_nxt.hold = 1'b0;
            s_nxt.wake = 1'b0;
          end
        end
        OFF_DATA: s_nxt.data = pwdata[7:0];
        default: ;
      endcase
    end

    // bus events come after the register write so that a set beats a clear
    if (!s_r.en) begin
      s_nxt.st      = D_IDLE;
      s_nxt.sda_drv = 1'b0;
      s_nxt.hold    = 1'b0;
      s_nxt.addrd   = 1'b0;
    end else if (start_seen || stop_seen) begin
      if (s_r.addrd) begin
        s_nxt.flag = 1'b1;
        s_nxt.stat = STAT_STOP;
      end
      s_nxt.addrd   = 1'b0;
      s_nxt.sda_drv = 1'b0;
      s_nxt.cnt     = 4'h0;
      s_nxt.st      = start_seen ? D_ADDR : D_IDLE;
    end else begin
      unique case (s_r.st)
        D_IDLE: ;
        D_ADDR: begin
          if (scl_rise) begin
            s_nxt.sh  = {s_r.sh[6:0], s_r.sda_f};
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else if (scl_fall && (s_r.cnt == BYTE_BITS)) begin
            // a read request falls to the transmitter, which is not built here
            if (s_r.ea && !s_r.sh[0] && (own_hit || gc_hit)) begin
              s_nxt.sda_drv = 1'b1;
              s_nxt.gc      = (s_r.sh[7:1] == GC_ADDR);
              s_nxt.st      = D_AACK;
            end else begin
              s_nxt.st = D_IDLE;
            end
          end
        end
        D_AACK: begin
          if (scl_fall) begin
            s_nxt.sda_drv = 1'b0;
            s_nxt.flag    = 1'b1;
            s_nxt.hold    = 1'b1;
            s_nxt.addrd   = 1'b1;
            s_nxt.cnt     = 4'h0;
            // the address byte never reaches the data register
            s_nxt.wake    = sleep_mode;
            if (s_r.gc) begin
              s_nxt.stat = arb_lost ? STAT_GC_AL : STAT_GC;
            end else begin
              s_nxt.stat = arb_lost ? STAT_OWN_AL : STAT_OWN;
            end
            s_nxt.st = D_DATA;
          end
        end
        D_DATA: begin
          if (scl_rise) begin
            s_nxt.sh  = {s_r.sh[6:0], s_r.sda_f};
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else if (scl_fall && (s_r.cnt == BYTE_BITS)) begin
            s_nxt.ackd    = s_r.ea;
            s_nxt.sda_drv = s_r.ea;
            s_nxt.data    = s_r.sh;
            s_nxt.st      = D_DACK;
          end
        end
        D_DACK: begin
          if (scl_fall) begin
            s_nxt.sda_drv = 1'b0;
            s_nxt.flag    = 1'b1;
            s_nxt.hold    = 1'b1;
            s_nxt.cnt     = 4'h0;
            if (s_r.ackd) begin
              s_nxt.stat = s_r.gc ? STAT_GDAT_A : STAT_DAT_A;
              s_nxt.st   = D_DATA;
            end else begin
              s_nxt.stat  = s_r.gc ? STAT_GDAT_N : STAT_DAT_N;
              s_nxt.addrd = 1'b0;
              s_nxt.st    = D_IDLE;
            end
          end
        end
        default: s_nxt.st = D_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= D_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata       = {24'h000000, s_r.rdata};
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && unmapped;
  assign wake_req     = s_r.wake;
  assign bus.s_scl_o  = 1'b0;
  assign bus.s_sda_o  = 1'b0;
  // stretching lasts until the flag is cleared; a long wake-up blocks the bus
  assign bus.s_scl_oe = s_r.hold;
  assign bus.s_sda_oe = s_r.sda_drv;

endmodule
`default_nettype wire

// >>> dv/tws_assertions.sv
// wire-level checks on the two-wire link between the master and slave ends
// assumes the plain signals of tws_bus_if and one pclk domain
`timescale 1ns/1ps
`default_nettype none
module tws_assertions
  import tws_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_scl_o,
  input wire logic m_sda_o,
  input wire logic s_scl_o,
  input wire logic s_scl_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe
);
  // an acknowledge spans one bit, so five quarters bounds it with margin
  localparam int LIM = 5 * QTR;

  typedef struct packed {
    logic       scl;
    logic       sda;
    logic [3:0] bits;
    logic [9:0] hold;
  } tws_chk_t;

  tws_chk_t chk_r;
  tws_chk_t chk_nxt;

  // bit slot count from raw scl rises; a start clears it
  always_comb begin
    chk_nxt = chk_r;
    chk_nxt.scl = scl;
    chk_nxt.sda = sda;
    chk_nxt.hold = s_sda_oe ? chk_r.hold + 10'h001 : 10'h000;
    if (chk_r.scl && scl && chk_r.sda && !sda) begin
      chk_nxt.bits = 4'h0;
    end else if (!chk_r.scl && scl) begin
      chk_nxt.bits = (chk_r.bits == 4'h9) ? 4'h1 : chk_r.bits + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_r <= '{scl: 1'b1, sda: 1'b1, bits: 4'h0, hold: 10'h000};
    end else begin
      chk_r <= chk_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ack_win_s;
    scl && s_sda_oe;
  endsequence
  sequence byte_end_s;
    !scl && chk_r.bits == 4'h9;
  endsequence

  open_drain_a: assert property (!s_scl_o && !s_sda_o && !m_scl_o && !m_sda_o)
    else $error("line driven high");
  ack_slot_a: assert property ($rose(s_sda_oe) |-> !scl && chk_r.bits == 4'h8)
    else $error("ack raised outside ack slot");
  ack_end_a: assert property ($fell(s_sda_oe) |-> byte_end_s)
    else $error("ack released outside ack slot");
  ack_seen_a: assert property ($rose(s_sda_oe) |-> ##[1:200] ack_win_s)
    else $error("ack not shown while scl high");
  ack_hold_a: assert property (ack_win_s |=> s_sda_oe)
    else $error("ack dropped while scl high");
  data_quiet_a: assert property (s_sda_oe |-> chk_r.bits >= 4'h8)
    else $error("slave drove sda in a data bit");
  stretch_at_a: assert property ($rose(s_scl_oe) |-> byte_end_s ##0 !$past(scl))
    else $error("stretch begun outside ninth bit low");
  ack_len_a: assert property (chk_r.hold < LIM)
    else $error("ack held too long");
endmodule
`default_nettype wire

// >>> dv/two_wire_slave_receiver_tb.sv
// self-checking bench: master end drives the link, apb reaches the slave end
// assumes a shortened quarter of 8 pclk on the master and a 100 MHz pclk
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_receiver_tb
  import tws_pkg::*;
;
  localparam int QTR = 8;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_mode;
  logic        arb_lost;
  logic        wake_req;
  logic        cmd_valid;
  tws_op_t     cmd_op;
  logic [7:0]  cmd_byte;
  logic        cmd_ready;
  logic        nack_seen;
  logic [7:0]  rq;
  logic        re;
  int          failures;
  int          cmp_count;
  logic [7:0]  bad [3] = '{8'h56, 8'hD4, 8'h55};
  // status, address byte, {sleep, arbitration lost}
  logic [23:0] tbl [4] = '{24'h68_54_01, 24'h78_00_01, 24'h60_54_02, 24'h70_00_02};

  tws_bus_if bus ();
  tws_mst #(.QTR(QTR)) tws_mst_i (.pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .nack_seen(nack_seen),
    .bus(bus));
  tws_dev tws_dev_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_mode(sleep_mode), .arb_lost(arb_lost), .wake_req(wake_req),
    .bus(bus));
  tws_assertions #(.QTR(QTR)) tws_assertions_i (.pclk(pclk), .presetn(presetn),
    .scl(bus.scl), .sda(bus.sda), .m_scl_o(bus.m_scl_o), .m_sda_o(bus.m_sda_o),
    .s_scl_o(bus.s_scl_o), .s_scl_oe(bus.s_scl_oe), .s_sda_o(bus.s_sda_o),
    .s_sda_oe(bus.s_sda_oe));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic finish_test;
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; an idle edge follows so psel never toggles in one step
  task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       e;
    rw(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] q;
    logic       e;
    rw(1'b0, a, 8'h00, q, e);
    ck(q, x);
  endtask

  task automatic clr;
    wr(OFF_CTL, 8'hC4);
  endtask

  task automatic wflag;
    logic [7:0] q;
    logic       e;
    int         n;
    n = 0;
    q = 8'h00;
    while (q[CTL_FLAG] !== 1'b1 && n < 400) begin
      rw(1'b0, OFF_CTL, 8'h00, q, e);
      n++;
    end
    ck(8'(q[CTL_FLAG]), 8'h01);
  endtask

  task automatic cmd(input tws_op_t op, input logic [7:0] b);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_byte <= b;
    @(posedge pclk);
    while (cmd_ready !== 1'b1) @(posedge pclk);
    cmd_valid <= 1'b0;
    @(posedge pclk);
    while (cmd_ready !== 1'b1) @(posedge pclk);
  endtask

  task automatic tx(input logic [7:0] b, input logic nk, input logic [7:0] st);
    cmd(OP_BYTE, b);
    ck(8'(nack_seen), 8'(nk));
    if (st != 8'h00) begin
      wflag();
      rd(OFF_STAT, st);
    end
  endtask

  // addressed session ended by a stop; the data register keeps the last data byte
  task automatic adr(input logic [7:0] b, input logic [7:0] st);
    cmd(OP_START, 8'h00);
    tx(b, 1'b0, st);
    ck(8'(wake_req), 8'(sleep_mode));
    ck(8'(bus.s_scl_oe), 8'h01);
    rd(OFF_DATA, 8'h11);
    clr();
    @(posedge pclk);
    ck(8'(wake_req), 8'h00);
    cmd(OP_STOP, 8'h00);
    wflag();
    rd(OFF_STAT, STAT_STOP);
    clr();
  endtask

  initial begin
    failures = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep_mode = 1'b0;
    arb_lost = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_byte = 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(OFF_SAR, SAR_RST);
    rd(OFF_CTL, 8'h00);
    rd(OFF_STAT, STAT_IDLE);
    rd(OFF_DATA, DATA_RST);
    rw(1'b0, 8'h10, 8'h00, rq, re);
    ck(8'(re), 8'h01);
    ck(rq, 8'h00);
    wr(OFF_STAT, 8'h00);
    rd(OFF_STAT, STAT_IDLE);
    // start, stop and interrupt enable are stored; write collision and bit one read zero
    wr(OFF_CTL, 8'h3D);
    rd(OFF_CTL, 8'h35);
    wr(OFF_DATA, 8'h5A);
    rd(OFF_DATA, 8'h5A);
    wr(OFF_SAR, 8'h55);
    wr(OFF_CTL, 8'h44);
    rd(OFF_CTL, 8'h44);
    for (int i = 0; i < 3; i++) begin
      cmd(OP_START, 8'h00);
      tx(bad[i], 1'b1, 8'h00);
      cmd(OP_STOP, 8'h00);
    end
    rd(OFF_CTL, 8'h44);
    cmd(OP_START, 8'h00);
    tx(8'h54, 1'b0, STAT_OWN);
    wr(OFF_CTL, 8'h44);
    rd(OFF_CTL, 8'hC4);
    ck(8'(bus.s_scl_oe), 8'h01);
    clr();
    @(posedge pclk);
    ck(8'(bus.s_scl_oe), 8'h00);
    tx(8'hA5, 1'b0, STAT_DAT_A);
    rd(OFF_DATA, 8'hA5);
    wr(OFF_CTL, 8'h84);
    tx(8'h3C, 1'b1, STAT_DAT_N);
    rd(OFF_DATA, 8'h3C);
    clr();
    tx(8'h77, 1'b1, 8'h00);
    cmd(OP_STOP, 8'h00);
    rd(OFF_CTL, 8'h44);
    wr(OFF_CTL, 8'h04);
    cmd(OP_START, 8'h00);
    tx(8'h54, 1'b1, 8'h00);
    cmd(OP_STOP, 8'h00);
    wr(OFF_CTL, 8'h44);
    cmd(OP_START, 8'h00);
    tx(8'h00, 1'b0, STAT_GC);
    clr();
    tx(8'h11, 1'b0, STAT_GDAT_A);
    clr();
    cmd(OP_STOP, 8'h00);
    wflag();
    rd(OFF_STAT, STAT_STOP);
    clr();
    for (int i = 0; i < 4; i++) begin
      arb_lost <= tbl[i][0];
      sleep_mode <= tbl[i][1];
      adr(tbl[i][15:8], tbl[i][23:16]);
    end
    arb_lost <= 1'b0;
    sleep_mode <= 1'b0;
    wr(OFF_SAR, 8'h54);
    cmd(OP_START, 8'h00);
    tx(8'h00, 1'b1, 8'h00);
    cmd(OP_STOP, 8'h00);
    finish_test();
  end

  // the tests need some 5300 cycles; over ten times that means a hang
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
